// *** rtl/slau_pkg.sv ***
// Purpose: Shared constants and types for the shift and logic ALU unit
// Assumes: 32-bit AXI4-Lite register access, 8-bit datapath
// Notes: Register offsets are byte addresses, one aligned word each
package slau_pkg;
    // Datapath and bus widths
    localparam int unsigned SLAU_DATA_W = 8;
    localparam int unsigned SLAU_ADDR_W = 8;
    localparam int unsigned SLAU_OP_W = 5;
    // Register byte offsets
    localparam logic [7:0] SLAU_ACC_OFS = 8'h00;
    localparam logic [7:0] SLAU_FLAGS_OFS = 8'h04;
    localparam logic [7:0] SLAU_OPND_OFS = 8'h08;
    localparam logic [7:0] SLAU_CMD_OFS = 8'h0c;
    localparam logic [7:0] SLAU_WBDATA_OFS = 8'h10;
    localparam logic [7:0] SLAU_STATUS_OFS = 8'h14;
    // Flag bit positions inside the flags register
    localparam int unsigned SLAU_Z_BIT = 0;
    localparam int unsigned SLAU_C_BIT = 1;
    localparam int unsigned SLAU_AUX_CARRY_BIT = 2;
    localparam int unsigned SLAU_OVERFLOW_BIT = 3;
    // Status bit positions
    localparam int unsigned SLAU_MEMWB_BIT = 0;
    localparam int unsigned SLAU_IOWB_BIT = 1;
    localparam int unsigned SLAU_BADOP_BIT = 2;
    // Values after reset
    localparam logic [7:0] SLAU_ACC_RST = 8'h00;
    localparam logic [3:0] SLAU_FLAGS_RST = 4'h0;
    localparam logic [7:0] SLAU_BYTE_RST = 8'h00;
    // AXI response codes
    localparam logic [1:0] SLAU_RESP_OKAY = 2'b00;
    localparam logic [1:0] SLAU_RESP_SLVERR = 2'b10;

    // Operations started by a write to the command register
    typedef enum logic [4:0] {
        SLAU_OP_SHR_A = 5'h00, SLAU_OP_RCR_A = 5'h01,
        SLAU_OP_SHR_M = 5'h02, SLAU_OP_RCR_M = 5'h03,
        SLAU_OP_SHL_A = 5'h04, SLAU_OP_RCL_A = 5'h05,
        SLAU_OP_SHL_M = 5'h06, SLAU_OP_RCL_M = 5'h07,
        SLAU_OP_SWAP_A = 5'h08,
        SLAU_OP_AND_AI = 5'h09, SLAU_OP_AND_AM = 5'h0a, SLAU_OP_AND_MA = 5'h0b,
        SLAU_OP_OR_AI = 5'h0c, SLAU_OP_OR_AM = 5'h0d, SLAU_OP_OR_MA = 5'h0e,
        SLAU_OP_XOR_AI = 5'h0f, SLAU_OP_XOR_IOA = 5'h10,
        SLAU_OP_XOR_AM = 5'h11, SLAU_OP_XOR_MA = 5'h12
    } slau_op_t;

    // Destination of an operation result
    typedef enum logic [1:0] {
        SLAU_DST_NONE = 2'b00, SLAU_DST_ACC = 2'b01,
        SLAU_DST_MEM = 2'b10, SLAU_DST_IO = 2'b11
    } slau_dst_t;

    // Write channel states, Gray coded along idle, execute, respond
    typedef enum logic [1:0] {
        SLAU_WS_IDLE = 2'b00, SLAU_WS_EXEC = 2'b01, SLAU_WS_RESP = 2'b11
    } slau_wstate_t;
endpackage

// *** rtl/slau_top.sv ***
// Purpose: Eight-bit shift, rotate, swap and logic unit with AXI4-Lite registers
// Assumes: Operand byte for memory or I/O operations is written to the operand register
// Notes: Results bound for memory or I/O land in the write-back register
// Notes on behaviour
// - Accumulator shift right, zero in, b0 to carry
// - Accumulator rotate right through carry
// - Memory shift right, zero in, b0 to carry
// - Memory rotate right through carry
// - Accumulator shift left, zero in, b7 to carry
// - Accumulator rotate left through carry
// - Memory shift left, zero in, b7 to carry
// - Memory rotate left through carry
// - Shifts change only the carry flag
// - Swap accumulator nibbles, flags untouched
// - AND immediate into accumulator
// - AND memory into accumulator or memory
// - OR immediate into accumulator
// - OR memory into accumulator or memory
// - XOR immediate into accumulator
// - XOR accumulator into I/O, flags untouched
// - XOR memory into accumulator or memory
// - Logic ops other than XOR into I/O update zero only
`timescale 1ns/1ps
`default_nettype none
module slau_top (
    input wire logic aclk, // 10 MHz clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [slau_pkg::SLAU_ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [slau_pkg::SLAU_ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready // Read data ready
);
    import slau_pkg::*;

    slau_wstate_t ws_r;
    logic aw_got_r, w_got_r, wlane_r, mem_wb_r, io_wb_r, bad_op_r;
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [SLAU_ADDR_W-1:0] waddr_r;
    logic [7:0] wbyte_r, acc_r, opnd_r, wb_byte_r, res;
    logic [3:0] flags_r;
    logic [4:0] cmd_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic exec, cy, cy_upd, z_upd, legal;
    slau_dst_t dst;

    // Word match on an aligned register offset
    function automatic logic hit(input logic [SLAU_ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    // Known register offset
    function automatic logic mapped(input logic [SLAU_ADDR_W-1:0] a);
        mapped = hit(a, SLAU_ACC_OFS) || hit(a, SLAU_FLAGS_OFS) || hit(a, SLAU_OPND_OFS)
            || hit(a, SLAU_CMD_OFS) || hit(a, SLAU_WBDATA_OFS) || hit(a, SLAU_STATUS_OFS);
    endfunction

    // Right shift, returns {old b0, fill, b7..b1}
    function automatic logic [8:0] shr(input logic [7:0] v, input logic fill);
        shr = {v[0], fill, v[7:1]};
    endfunction

    // Left shift, returns {old b7, b6..b0, fill}
    function automatic logic [8:0] shl(input logic [7:0] v, input logic fill);
        shl = {v[7], v[6:0], fill};
    endfunction

    // Command write executes two cycles after both channels are taken
    assign exec = (ws_r == SLAU_WS_EXEC) && wlane_r && hit(waddr_r, SLAU_CMD_OFS);

    // Operation decode and result
    always_comb begin
        res = acc_r;
        cy = flags_r[SLAU_C_BIT];
        cy_upd = 1'b0;
        z_upd = 1'b0;
        legal = 1'b1;
        dst = SLAU_DST_NONE;
        unique case (wbyte_r[4:0])
            SLAU_OP_SHR_A, SLAU_OP_RCR_A: begin
                {cy, res} = shr(acc_r, wbyte_r[0] & flags_r[SLAU_C_BIT]);
                cy_upd = 1'b1; // Odd opcodes rotate through carry
                dst = SLAU_DST_ACC;
            end
            SLAU_OP_SHR_M, SLAU_OP_RCR_M: begin
                {cy, res} = shr(opnd_r, wbyte_r[0] & flags_r[SLAU_C_BIT]);
                cy_upd = 1'b1;
                dst = SLAU_DST_MEM;
            end
            SLAU_OP_SHL_A, SLAU_OP_RCL_A: begin
                {cy, res} = shl(acc_r, wbyte_r[0] & flags_r[SLAU_C_BIT]);
                cy_upd = 1'b1;
                dst = SLAU_DST_ACC;
            end
            SLAU_OP_SHL_M, SLAU_OP_RCL_M: begin
                {cy, res} = shl(opnd_r, wbyte_r[0] & flags_r[SLAU_C_BIT]);
                cy_upd = 1'b1;
                dst = SLAU_DST_MEM;
            end
            SLAU_OP_SWAP_A: begin
                res = {acc_r[3:0], acc_r[7:4]};
                dst = SLAU_DST_ACC;
            end
            SLAU_OP_AND_AI, SLAU_OP_AND_AM, SLAU_OP_AND_MA: begin
                res = acc_r & opnd_r;
                z_upd = 1'b1;
                dst = (wbyte_r[4:0] == SLAU_OP_AND_MA) ? SLAU_DST_MEM : SLAU_DST_ACC;
            end
            SLAU_OP_OR_AI, SLAU_OP_OR_AM, SLAU_OP_OR_MA: begin
                res = acc_r | opnd_r;
                z_upd = 1'b1;
                dst = (wbyte_r[4:0] == SLAU_OP_OR_MA) ? SLAU_DST_MEM : SLAU_DST_ACC;
            end
            SLAU_OP_XOR_AI, SLAU_OP_XOR_AM, SLAU_OP_XOR_MA: begin
                res = acc_r ^ opnd_r;
                z_upd = 1'b1;
                dst = (wbyte_r[4:0] == SLAU_OP_XOR_MA) ? SLAU_DST_MEM : SLAU_DST_ACC;
            end
            SLAU_OP_XOR_IOA: begin
                res = acc_r ^ opnd_r;
                dst = SLAU_DST_IO;
            end
            default: begin
                legal = 1'b0;
            end
        endcase
    end

    // Write address and data capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            waddr_r <= '0;
            wbyte_r <= SLAU_BYTE_RST;
            wlane_r <= 1'b0;
        end else if (ws_r == SLAU_WS_IDLE) begin
            if (s_axi_awvalid && awready_r) begin
                aw_got_r <= 1'b1;
                awready_r <= 1'b0;
                waddr_r <= s_axi_awaddr;
            end else begin
                awready_r <= !aw_got_r;
            end
            if (s_axi_wvalid && wready_r) begin
                w_got_r <= 1'b1;
                wready_r <= 1'b0;
                wbyte_r <= s_axi_wdata[7:0];
                wlane_r <= s_axi_wstrb[0];
            end else begin
                wready_r <= !w_got_r;
            end
        end else begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
        end
    end

    // Write channel sequencing and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ws_r <= SLAU_WS_IDLE;
            bvalid_r <= 1'b0;
            bresp_r <= SLAU_RESP_OKAY;
        end else begin
            unique case (ws_r)
                SLAU_WS_IDLE: begin
                    if (aw_got_r && w_got_r) begin
                        ws_r <= SLAU_WS_EXEC;
                    end
                end
                SLAU_WS_EXEC: begin
                    ws_r <= SLAU_WS_RESP;
                    bvalid_r <= 1'b1;
                    bresp_r <= mapped(waddr_r) ? SLAU_RESP_OKAY : SLAU_RESP_SLVERR;
                end
                SLAU_WS_RESP: begin
                    if (s_axi_bready) begin
                        ws_r <= SLAU_WS_IDLE;
                        bvalid_r <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Accumulator, flags and operand registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_r <= SLAU_ACC_RST;
            flags_r <= SLAU_FLAGS_RST;
            opnd_r <= SLAU_BYTE_RST;
            cmd_r <= '0;
        end else if ((ws_r == SLAU_WS_EXEC) && wlane_r) begin
            if (hit(waddr_r, SLAU_ACC_OFS)) begin
                acc_r <= wbyte_r;
            end
            if (hit(waddr_r, SLAU_FLAGS_OFS)) begin
                flags_r <= wbyte_r[3:0];
            end
            if (hit(waddr_r, SLAU_OPND_OFS)) begin
                opnd_r <= wbyte_r;
            end
            if (exec) begin
                cmd_r <= wbyte_r[4:0];
                if (legal && dst == SLAU_DST_ACC) begin
                    acc_r <= res;
                end
                if (legal && cy_upd) begin
                    flags_r[SLAU_C_BIT] <= cy;
                end
                if (legal && z_upd) begin
                    flags_r[SLAU_Z_BIT] <= (res == 8'h00);
                end
            end
        end
    end

    // Write-back byte for memory or I/O and execution status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wb_byte_r <= SLAU_BYTE_RST;
            mem_wb_r <= 1'b0;
            io_wb_r <= 1'b0;
            bad_op_r <= 1'b0;
        end else if (exec) begin
            mem_wb_r <= legal && (dst == SLAU_DST_MEM);
            io_wb_r <= legal && (dst == SLAU_DST_IO);
            bad_op_r <= !legal;
            if (legal && (dst == SLAU_DST_MEM || dst == SLAU_DST_IO)) begin
                wb_byte_r <= res;
            end
        end
    end

    // Read channel, one outstanding read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= SLAU_RESP_OKAY;
        end else if (rvalid_r) begin
            if (s_axi_rready) begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= mapped(s_axi_araddr) ? SLAU_RESP_OKAY : SLAU_RESP_SLVERR;
            rdata_r <= '0;
            if (hit(s_axi_araddr, SLAU_ACC_OFS)) rdata_r[7:0] <= acc_r;
            if (hit(s_axi_araddr, SLAU_FLAGS_OFS)) rdata_r[3:0] <= flags_r;
            if (hit(s_axi_araddr, SLAU_OPND_OFS)) rdata_r[7:0] <= opnd_r;
            if (hit(s_axi_araddr, SLAU_CMD_OFS)) rdata_r[4:0] <= cmd_r;
            if (hit(s_axi_araddr, SLAU_WBDATA_OFS)) rdata_r[7:0] <= wb_byte_r;
            if (hit(s_axi_araddr, SLAU_STATUS_OFS)) begin
                rdata_r[2:0] <= {bad_op_r, io_wb_r, mem_wb_r};
            end
        end else begin
            arready_r <= 1'b1;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // Snapshot of the state an operation started from
    logic ex_d;
    logic [4:0] op_d;
    logic [7:0] acc_d, opnd_d;
    logic [3:0] fl_d;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ex_d <= 1'b0;
            op_d <= '0;
            acc_d <= '0;
            opnd_d <= '0;
            fl_d <= '0;
        end else begin
            ex_d <= exec;
            op_d <= wbyte_r[4:0];
            acc_d <= acc_r;
            opnd_d <= opnd_r;
            fl_d <= flags_r;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_shr_acc: assert property (ex_d && op_d == SLAU_OP_SHR_A |->
        acc_r == {1'b0, acc_d[7:1]} && flags_r[SLAU_C_BIT] == acc_d[0]) else $error("shr acc");
    a_rcr_acc: assert property (ex_d && op_d == SLAU_OP_RCR_A |->
        acc_r == {fl_d[SLAU_C_BIT], acc_d[7:1]} && flags_r[SLAU_C_BIT] == acc_d[0])
        else $error("rcr acc");
    a_shr_mem: assert property (ex_d && op_d == SLAU_OP_SHR_M |->
        wb_byte_r == {1'b0, opnd_d[7:1]} && flags_r[SLAU_C_BIT] == opnd_d[0] && mem_wb_r)
        else $error("shr mem");
    a_rcr_mem: assert property (ex_d && op_d == SLAU_OP_RCR_M |->
        wb_byte_r == {fl_d[SLAU_C_BIT], opnd_d[7:1]} && flags_r[SLAU_C_BIT] == opnd_d[0])
        else $error("rcr mem");
    a_shl_acc: assert property (ex_d && op_d == SLAU_OP_SHL_A |->
        acc_r == {acc_d[6:0], 1'b0} && flags_r[SLAU_C_BIT] == acc_d[7]) else $error("shl acc");
    a_rcl_acc: assert property (ex_d && op_d == SLAU_OP_RCL_A |->
        acc_r == {acc_d[6:0], fl_d[SLAU_C_BIT]} && flags_r[SLAU_C_BIT] == acc_d[7])
        else $error("rcl acc");
    a_shl_mem: assert property (ex_d && op_d == SLAU_OP_SHL_M |->
        wb_byte_r == {opnd_d[6:0], 1'b0} && flags_r[SLAU_C_BIT] == opnd_d[7]) else $error("shl mem");
    a_rcl_mem: assert property (ex_d && op_d == SLAU_OP_RCL_M |->
        wb_byte_r == {opnd_d[6:0], fl_d[SLAU_C_BIT]} && flags_r[SLAU_C_BIT] == opnd_d[7])
        else $error("rcl mem");
    a_shift_flags: assert property (ex_d && op_d <= SLAU_OP_RCL_M |->
        flags_r[SLAU_Z_BIT] == fl_d[SLAU_Z_BIT] && flags_r[3:2] == fl_d[3:2]) else $error("shift flags");
    a_swap_acc: assert property (ex_d && op_d == SLAU_OP_SWAP_A |->
        acc_r == {acc_d[3:0], acc_d[7:4]} && flags_r == fl_d) else $error("swap");
    a_and_imm: assert property (ex_d && op_d == SLAU_OP_AND_AI |->
        acc_r == (acc_d & opnd_d)) else $error("and imm");
    a_and_mem: assert property (ex_d && op_d == SLAU_OP_AND_MA |->
        wb_byte_r == (acc_d & opnd_d) && acc_r == acc_d) else $error("and mem");
    a_or_imm: assert property (ex_d && op_d == SLAU_OP_OR_AI |->
        acc_r == (acc_d | opnd_d)) else $error("or imm");
    a_or_mem: assert property (ex_d && op_d == SLAU_OP_OR_MA |->
        wb_byte_r == (acc_d | opnd_d) && mem_wb_r) else $error("or mem");
    a_xor_imm: assert property (ex_d && op_d == SLAU_OP_XOR_AI |->
        acc_r == (acc_d ^ opnd_d)) else $error("xor imm");
    a_xor_io: assert property (ex_d && op_d == SLAU_OP_XOR_IOA |->
        wb_byte_r == (acc_d ^ opnd_d) && io_wb_r && flags_r == fl_d) else $error("xor io");
    a_xor_mem: assert property (ex_d && op_d == SLAU_OP_XOR_AM |->
        acc_r == (acc_d ^ opnd_d)) else $error("xor mem");
    a_logic_flags: assert property (ex_d && op_d >= SLAU_OP_AND_AI
        && op_d <= SLAU_OP_XOR_MA && op_d != SLAU_OP_XOR_IOA |-> flags_r[3:1] == fl_d[3:1])
        else $error("logic flags");
    a_zero_value: assert property (ex_d && op_d == SLAU_OP_OR_AM |->
        flags_r[SLAU_Z_BIT] == ((acc_d | opnd_d) == 8'h00)) else $error("zero flag");
    a_bresp_time: assert property (exec |=> s_axi_bvalid) else $error("late write response");

    c_rotate: cover property (ex_d && op_d == SLAU_OP_RCL_A && fl_d[SLAU_C_BIT]);
    c_zero: cover property (ex_d && op_d == SLAU_OP_AND_AI && flags_r[SLAU_Z_BIT]);
    c_io_xor: cover property (ex_d && op_d == SLAU_OP_XOR_IOA);
    c_bad_op: cover property (exec && !legal);
endmodule // slau_top
`default_nettype wire

// *** verif/slau_master.sv ***
// Purpose: AXI4-Lite master standing in for the CPU side of the unit
// Assumes: The unit answers each transfer within 200 cycles
// Notes: Signals change by non-blocking assignment after a rising edge, apart from the blocking defaults set at time zero
`timescale 1ns/1ps
`default_nettype none
module slau_master (
    input wire logic aclk, // Clock
    output logic [slau_pkg::SLAU_ADDR_W-1:0] awaddr, // Write address
    output logic awvalid, // Write address valid
    input wire logic awready, // Write address ready
    output logic [31:0] wdata, // Write data
    output logic [3:0] wstrb, // Write strobes
    output logic wvalid, // Write data valid
    input wire logic wready, // Write data ready
    input wire logic [1:0] bresp, // Write response
    input wire logic bvalid, // Write response valid
    output logic bready, // Write response ready
    output logic [slau_pkg::SLAU_ADDR_W-1:0] araddr, // Read address
    output logic arvalid, // Read address valid
    input wire logic arready, // Read address ready
    input wire logic [31:0] rdata, // Read data
    input wire logic [1:0] rresp, // Read response
    input wire logic rvalid, // Read data valid
    output logic rready // Read data ready
);
    import slau_pkg::*;
    bit tmo = 1'b0; // Set once an answer never came
    // Quiet bus from time zero
    initial begin
        awaddr = '0;
        wdata = '0;
        wstrb = '0;
        araddr = '0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    end
    // One write; address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            output logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 200);
        r = bresp;
        bready <= 1'b0;
        if (!bvalid) tmo = 1'b1;
    endtask
    // One read; data and response taken at the edge rvalid is seen
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 200);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (!rvalid) tmo = 1'b1;
    endtask
endmodule // slau_master
`default_nettype wire

// *** verif/slau_top_bench.sv ***
// Purpose: Self-checking bench for the shift and logic unit
// Assumes: Register map and opcodes as set in the package
// Notes: Expected values come from the small reference model below
`timescale 1ns/1ps
`default_nettype none
module slau_top_bench;
    import slau_pkg::*;
    logic aclk, aresetn;
    logic [SLAU_ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    int mismatches = 0;
    int n_compared = 0;
    slau_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    slau_master bus (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    // Clock, 100 ns period
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // Verdict and end of run
    task automatic end_sim();
        if (bus.tmo) mismatches++;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Response and data compared together
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Reference model of one command: accumulator, write-back, flags, status
    function automatic void model(input logic [4:0] op, input logic [7:0] a, m,
            input logic [3:0] f, output logic [7:0] na, nw, output logic [3:0] nf,
            output logic [2:0] st);
        logic [7:0] s, r;
        s = op[1] ? m : a;
        na = a;
        nw = 8'h00;
        nf = f;
        st = 3'b000;
        if (op < 5'h08) begin
            r = op[2] ? {s[6:0], op[0] & f[SLAU_C_BIT]} : {op[0] & f[SLAU_C_BIT], s[7:1]};
            nf[SLAU_C_BIT] = op[2] ? s[7] : s[0];
            st[0] = op[1];
            if (op[1]) nw = r;
            else na = r;
        end else if (op == 5'h08) begin
            na = {a[3:0], a[7:4]};
        end else if (op > 5'h12) begin
            st[2] = 1'b1;
        end else begin
            r = (op < 5'h0c) ? (a & m) : (op < 5'h0f) ? (a | m) : (a ^ m);
            if (op != 5'h10) nf[SLAU_Z_BIT] = (r == 8'h00);
            st[0] = op inside {5'h0b, 5'h0e, 5'h12};
            st[1] = (op == 5'h10);
            if (st[1:0] != 2'b00) nw = r;
            else na = r;
        end
    endfunction
    // Load registers, issue one command, check every visible result
    task automatic run_op(input logic [4:0] op, input logic [7:0] a, m, input logic [3:0] f);
        logic [7:0] na, nw;
        logic [3:0] nf;
        logic [2:0] st;
        logic [1:0] r;
        logic [31:0] d;
        model(op, a, m, f, na, nw, nf, st);
        bus.wr(SLAU_ACC_OFS, {24'h0, a}, 4'h1, r);
        bus.wr(SLAU_FLAGS_OFS, {28'h0, f}, 4'h1, r);
        bus.wr(SLAU_OPND_OFS, {24'h0, m}, 4'h1, r);
        bus.wr(SLAU_CMD_OFS, {27'h0, op}, 4'h1, r);
        chk({r, 32'h0}, {SLAU_RESP_OKAY, 32'h0});
        bus.rd(SLAU_ACC_OFS, d, r);
        chk({r, d}, {SLAU_RESP_OKAY, 24'h0, na});
        bus.rd(SLAU_FLAGS_OFS, d, r);
        chk({r, d}, {SLAU_RESP_OKAY, 28'h0, nf});
        bus.rd(SLAU_STATUS_OFS, d, r);
        chk({r, d}, {SLAU_RESP_OKAY, 29'h0, st});
        if (st[1:0] != 2'b00) begin
            bus.rd(SLAU_WBDATA_OFS, d, r);
            chk({r, d}, {SLAU_RESP_OKAY, 24'h0, nw});
        end
    endtask
    // Shifts and rotates, carry in and out both ways, other flags preset
    task automatic t_shifts();
        for (logic [4:0] op = 5'h00; op < 5'h08; op++) begin
            run_op(op, 8'h81, 8'hc3, 4'b1001);
            run_op(op, 8'h7e, 8'h3c, 4'b0110);
        end
    endtask
    // Nibble swap with all flags set and all clear
    task automatic t_swap();
        run_op(5'h08, 8'h3c, 8'h00, 4'hf);
        run_op(5'h08, 8'ha5, 8'h11, 4'h0);
    endtask
    // Every logic command with zero and non-zero results
    task automatic t_logic();
        for (logic [4:0] op = 5'h09; op < 5'h13; op++) begin
            run_op(op, 8'hc3, 8'h3c, 4'b1110);
            run_op(op, 8'h5a, 8'h5a, 4'b0001);
            run_op(op, 8'h00, 8'h00, 4'b1110);
        end
    endtask
    // Reset values, refused and ignored accesses, unknown opcode
    task automatic t_bus();
        logic [31:0] d;
        logic [1:0] r;
        bus.rd(SLAU_ACC_OFS, d, r);
        chk({r, d}, {SLAU_RESP_OKAY, 24'h0, SLAU_ACC_RST});
        bus.rd(SLAU_FLAGS_OFS, d, r);
        chk({r, d}, {SLAU_RESP_OKAY, 28'h0, SLAU_FLAGS_RST});
        bus.rd(8'h18, d, r);
        chk({r, d}, {SLAU_RESP_SLVERR, 32'h0});
        bus.wr(8'h20, 32'h0, 4'h1, r);
        chk({r, 32'h0}, {SLAU_RESP_SLVERR, 32'h0});
        run_op(5'h1f, 8'h55, 8'h33, 4'ha);
        bus.rd(SLAU_CMD_OFS, d, r);
        chk({r, d}, {SLAU_RESP_OKAY, 32'h1f});
        run_op(5'h0b, 8'hf0, 8'h3c, 4'h0);
        bus.wr(SLAU_WBDATA_OFS, 32'hff, 4'h1, r);
        bus.wr(SLAU_ACC_OFS, 32'h77, 4'h0, r);
        bus.rd(SLAU_WBDATA_OFS, d, r);
        chk({r, d}, {SLAU_RESP_OKAY, 32'h30});
        bus.rd(SLAU_ACC_OFS, d, r);
        chk({r, d}, {SLAU_RESP_OKAY, 32'hf0});
    endtask
    // Cut a hung transfer short
    initial begin
        wait (bus.tmo);
        end_sim();
    end
    // Main sequence
    initial begin
        aresetn = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_bus();
        t_shifts();
        t_swap();
        t_logic();
        end_sim();
    end
endmodule // slau_top_bench
`default_nettype wire
